/* rtl/crf_core_regs.sv */
/*
 * Core register file: result register, pointers and short-direct registers
 * on the data space, the program counter with its load sources, three
 * per-context flag pairs and a six-level return stack.
 * Assumes the sequencer issues at most one program-counter command per clock,
 * and that data-space reads are sampled one clock after the request.
 */
`timescale 1ns/1ps
`default_nettype none


module crf_core_regs
	import crf_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire crf_dbus_type dbus_in,
	input wire crf_pc_cmd_type pc_cmd_in,
	input wire logic [11:0] int_vector_in,
	input wire logic [11:0] nmi_vector_in,
	input wire crf_flag_upd_type flag_upd_in,
	output logic [7:0] rdata_out,
	output logic rvalid_out,
	output logic [11:0] program_counter_out,
	output logic [7:0] result_register_out,
	output logic [7:0] pointer_one_out,
	output logic [7:0] pointer_two_out,
	output crf_flags_type flags_out,
	output crf_ctx_type context_out,
	output logic [2:0] stack_depth_out
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0] result_register;
		logic [7:0] pointer_one;
		logic [7:0] pointer_two;
		logic [7:0] short_direct_first;
		logic [7:0] short_direct_second;
		logic [11:0] program_counter;
		crf_flags_type normal_pair;
		crf_flags_type interrupt_pair;
		crf_flags_type nmi_pair;
		crf_ctx_type ctx;
		crf_ctx_type ctx_saved;
		logic [STACK_DEPTH-1:0][11:0] stack;
		logic [2:0] depth;
		logic [7:0] rdata;
		logic rvalid;
		crf_flags_type flags;
	} crf_state_type;

	crf_state_type state_q;
	crf_state_type state_d;

	logic [12:0] rel_sum;
	crf_flags_type cur_pair;
	crf_flags_type new_pair;
	logic push;
	logic pop;

	// ****************************************
	// relative branch adder
	// ****************************************
	// offset and counter meet in one adder; the carry out is dropped, so a
	// branch target wraps inside the 4096-byte program space
	always_comb begin
		if (pc_cmd_in.backward) begin
			rel_sum = {1'b0, state_q.program_counter} - {5'h00, pc_cmd_in.offset};
		end else begin
			rel_sum = {1'b0, state_q.program_counter} + {5'h00, pc_cmd_in.offset};
		end
	end

	// ****************************************
	// flag pair of the running context
	// ****************************************
	always_comb begin
		case (state_q.ctx)
			CTX_NORMAL: cur_pair = state_q.normal_pair;
			CTX_INTERRUPT: cur_pair = state_q.interrupt_pair;
			CTX_NMI: cur_pair = state_q.nmi_pair;
			default: cur_pair = state_q.nmi_pair;
		endcase
		new_pair = cur_pair;
		if (flag_upd_in.carry_we) begin
			new_pair.carry = flag_upd_in.carry_val;
		end
		if (flag_upd_in.zero_we) begin
			new_pair.zero = flag_upd_in.zero_val;
		end
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		state_d = state_q;
		state_d.rvalid = 1'b0;
		push = 1'b0;
		pop = 1'b0;

		// data-space access; any other address is left to the rest of data space
		if (dbus_in.rd) begin
			state_d.rvalid = 1'b1;
			case (dbus_in.addr)
				ADDR_RESULT_REGISTER: state_d.rdata = state_q.result_register;
				ADDR_POINTER_ONE: state_d.rdata = state_q.pointer_one;
				ADDR_POINTER_TWO: state_d.rdata = state_q.pointer_two;
				ADDR_SHORT_DIRECT_FIRST: state_d.rdata = state_q.short_direct_first;
				ADDR_SHORT_DIRECT_SECOND: state_d.rdata = state_q.short_direct_second;
				default: begin
					state_d.rdata = REG_RESET;
					state_d.rvalid = 1'b0;
				end
			endcase
		end
		if (dbus_in.wr) begin
			case (dbus_in.addr)
				ADDR_RESULT_REGISTER: state_d.result_register = dbus_in.wdata;
				ADDR_POINTER_ONE: state_d.pointer_one = dbus_in.wdata;
				ADDR_POINTER_TWO: state_d.pointer_two = dbus_in.wdata;
				ADDR_SHORT_DIRECT_FIRST: state_d.short_direct_first = dbus_in.wdata;
				ADDR_SHORT_DIRECT_SECOND: state_d.short_direct_second = dbus_in.wdata;
				default: begin
				end
			endcase
		end

		// only the pair of the running context is written back; a switch in the
		// same clock takes effect afterwards, so the update lands in the old pair
		case (state_q.ctx)
			CTX_NORMAL: state_d.normal_pair = new_pair;
			CTX_INTERRUPT: state_d.interrupt_pair = new_pair;
			CTX_NMI: state_d.nmi_pair = new_pair;
			default: begin
			end
		endcase

		// program counter sources
		case (pc_cmd_in.op)
			PCS_HOLD: begin
			end
			PCS_INCREMENT: state_d.program_counter = state_q.program_counter + PC_ONE;
			PCS_RELATIVE: state_d.program_counter = rel_sum[11:0];
			PCS_JUMP_ABSOLUTE: state_d.program_counter = pc_cmd_in.target;
			PCS_CALL: begin
				state_d.program_counter = pc_cmd_in.target;
				push = 1'b1;
			end
			PCS_INTERRUPT: begin
				state_d.program_counter = int_vector_in;
				push = 1'b1;
				// pairs are switched, never cleared
				state_d.ctx_saved = state_q.ctx;
				state_d.ctx = CTX_INTERRUPT;
			end
			PCS_NMI: begin
				state_d.program_counter = nmi_vector_in;
				push = 1'b1;
				state_d.ctx_saved = state_q.ctx;
				state_d.ctx = CTX_NMI;
			end
			PCS_RETURN: begin
				if (state_q.depth != DEPTH_ZERO) begin
					state_d.program_counter = state_q.stack[0];
					pop = 1'b1;
				end else begin
					// empty stack: fall through to the next instruction
					state_d.program_counter = state_q.program_counter + PC_ONE;
				end
				if (pc_cmd_in.is_interrupt_exit) begin
					// one saved context only; nested nmi-in-interrupt returns to saved
					state_d.ctx = state_q.ctx_saved;
					state_d.ctx_saved = CTX_NORMAL;
				end
			end
			default: begin
			end
		endcase

		// return stack: a shift register, so there is no pointer to wrap
		if (push) begin
			for (int i = STACK_DEPTH - 1; i > 0; i--) begin
				state_d.stack[i] = state_q.stack[i-1];
			end
			state_d.stack[0] = state_q.program_counter;
			if (state_q.depth != DEPTH_FULL) begin
				state_d.depth = state_q.depth + DEPTH_ONE;
			end
		end else if (pop) begin
			for (int i = 0; i < STACK_DEPTH - 1; i++) begin
				state_d.stack[i] = state_q.stack[i+1];
			end
			state_d.depth = state_q.depth - DEPTH_ONE;
		end

		// the flag view is a register of its own, so the output needs no mux
		// after the flops; it follows the context of the next clock
		case (state_d.ctx)
			CTX_NORMAL: state_d.flags = state_d.normal_pair;
			CTX_INTERRUPT: state_d.flags = state_d.interrupt_pair;
			default: state_d.flags = state_d.nmi_pair;
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q.result_register <= REG_RESET;
			state_q.pointer_one <= REG_RESET;
			state_q.pointer_two <= REG_RESET;
			state_q.short_direct_first <= REG_RESET;
			state_q.short_direct_second <= REG_RESET;
			state_q.program_counter <= PC_RESET_VECTOR;
			state_q.normal_pair <= '0;
			state_q.interrupt_pair <= '0;
			state_q.nmi_pair <= '0;
			state_q.ctx <= CTX_NMI;
			state_q.ctx_saved <= CTX_NORMAL;
			state_q.stack <= '0;
			state_q.depth <= DEPTH_ZERO;
			state_q.rdata <= REG_RESET;
			state_q.rvalid <= 1'b0;
			state_q.flags <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	always_comb begin
		rdata_out = state_q.rdata;
		rvalid_out = state_q.rvalid;
		program_counter_out = state_q.program_counter;
		result_register_out = state_q.result_register;
		pointer_one_out = state_q.pointer_one;
		pointer_two_out = state_q.pointer_two;
		context_out = state_q.ctx;
		stack_depth_out = state_q.depth;
		flags_out = state_q.flags;
	end

endmodule

`default_nettype wire

/* rtl/crf_pkg.sv */
/*
 * Package for the core register file: data-space offsets, widths, reset
 * values, context and program-counter source codes, and the carrier structs.
 * Assumes it is compiled before every module that imports it.
 */
`default_nettype none

package crf_pkg;

	// ****************************************
	// widths and sizes
	// ****************************************
	localparam int DATA_W = 8;
	localparam int PC_W = 12;
	localparam int STACK_DEPTH = 6;
	localparam int DEPTH_W = 3;

	// ****************************************
	// data-space offsets
	// ****************************************
	localparam logic [7:0] ADDR_POINTER_ONE = 8'h80;
	localparam logic [7:0] ADDR_POINTER_TWO = 8'h81;
	localparam logic [7:0] ADDR_SHORT_DIRECT_FIRST = 8'h82;
	localparam logic [7:0] ADDR_SHORT_DIRECT_SECOND = 8'h83;
	localparam logic [7:0] ADDR_RESULT_REGISTER = 8'hFF;

	// ****************************************
	// reset values and vectors
	// ****************************************
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [11:0] PC_RESET_VECTOR = 12'hFFE;
	localparam logic [11:0] PC_ZERO = 12'h000;
	localparam logic [11:0] PC_ONE = 12'h001;
	localparam logic [2:0] DEPTH_ZERO = 3'h0;
	localparam logic [2:0] DEPTH_ONE = 3'h1;
	localparam logic [2:0] DEPTH_FULL = 3'h6;

	// ****************************************
	// enumerations
	// ****************************************
	typedef enum logic [1:0] {
		CTX_NORMAL,
		CTX_INTERRUPT,
		CTX_NMI
	} crf_ctx_type;

	typedef enum logic [2:0] {
		PCS_HOLD,
		PCS_INCREMENT,
		PCS_RELATIVE,
		PCS_JUMP_ABSOLUTE,
		PCS_CALL,
		PCS_INTERRUPT,
		PCS_NMI,
		PCS_RETURN
	} crf_pc_op_type;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} crf_dbus_type;

	typedef struct packed {
		logic carry;
		logic zero;
	} crf_flags_type;

	// carry and zero flag update presented by the execute stage
	typedef struct packed {
		logic carry_we;
		logic carry_val;
		logic zero_we;
		logic zero_val;
	} crf_flag_upd_type;

	typedef struct packed {
		crf_pc_op_type op;
		logic is_interrupt_exit;
		logic [11:0] target;
		logic [7:0] offset;
		logic backward;
	} crf_pc_cmd_type;

endpackage

`default_nettype wire

/* sim/crf_vec_model.sv */
/* vector table model: fixed handler addresses.
   assumes the bench feeds them to the vector inputs. */
`timescale 1ns/1ps
`default_nettype none
module crf_vec_model
	import crf_pkg::*;
(
	output logic [11:0] int_vector_out,
	output logic [11:0] nmi_vector_out
);
	// a programmed table never changes at run time
	assign int_vector_out = 12'h400;
	assign nmi_vector_out = 12'h500;
endmodule
`default_nettype wire

/* sim/crf_core_regs_assertions.sv */
/* checker on the core register file ports.
   assumes it is bound to the design top. */
`timescale 1ns/1ps
`default_nettype none
module crf_core_regs_assertions
	import crf_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire crf_dbus_type dbus_in,
	input wire crf_pc_cmd_type pc_cmd_in,
	input wire logic [11:0] int_vector_in,
	input wire crf_flag_upd_type flag_upd_in,
	input wire logic [7:0] rdata_out,
	input wire logic rvalid_out,
	input wire logic [11:0] program_counter_out,
	input wire logic [7:0] pointer_one_out,
	input wire crf_flags_type flags_out,
	input wire crf_ctx_type context_out,
	input wire logic [2:0] stack_depth_out
);
	// ****
	// properties
	// ****
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_call;
		pc_cmd_in.op == PCS_CALL && stack_depth_out < DEPTH_FULL;
	endsequence
	sequence s_ret;
		pc_cmd_in.op == PCS_RETURN && !pc_cmd_in.is_interrupt_exit;
	endsequence
	a_reset_state: assert property ($rose(rst_n_in) |-> context_out == CTX_NMI
		&& program_counter_out == PC_RESET_VECTOR) else $error("bad reset state");
	a_pc_inc: assert property (pc_cmd_in.op == PCS_INCREMENT
		|=> program_counter_out == $past(program_counter_out) + 12'h001) else $error("bad increment");
	a_pc_rel: assert property (pc_cmd_in.op == PCS_RELATIVE && !pc_cmd_in.backward
		|=> program_counter_out == $past(program_counter_out) + $past(pc_cmd_in.offset)) else $error("bad branch");
	a_int_entry: assert property (pc_cmd_in.op == PCS_INTERRUPT |=> context_out == CTX_INTERRUPT
		&& program_counter_out == $past(int_vector_in)) else $error("bad interrupt entry");
	a_call_return: assert property (s_call ##1 pc_cmd_in.op == PCS_HOLD ##1 s_ret
		|=> program_counter_out == $past(program_counter_out, 3)) else $error("bad call return");
	a_stack_full: assert property (pc_cmd_in.op == PCS_CALL && stack_depth_out == DEPTH_FULL
		|=> stack_depth_out == DEPTH_FULL) else $error("depth left full");
	a_ret_empty: assert property (pc_cmd_in.op == PCS_RETURN && stack_depth_out == DEPTH_ZERO
		|=> stack_depth_out == DEPTH_ZERO && program_counter_out == $past(program_counter_out) + 12'h001)
		else $error("bad empty return");
	a_flag_carry: assert property (flag_upd_in.carry_we && pc_cmd_in.op == PCS_HOLD
		|=> flags_out.carry == $past(flag_upd_in.carry_val)) else $error("carry not taken");
	a_read_map: assert property (dbus_in.rd && dbus_in.addr == ADDR_POINTER_ONE
		|=> rvalid_out && rdata_out == $past(pointer_one_out)) else $error("bad pointer read");
	a_read_unmap: assert property (dbus_in.rd && dbus_in.addr == 8'h84 |=> !rvalid_out)
		else $error("unmapped read answered");
endmodule
`default_nettype wire

/* sim/core_regs_flags_stack_test.sv */
/* self-checking bench for the core register file.
   assumes the design and vector model compile first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; $display("ERROR t=%0t %h %h", $time, a, b); end end
module core_regs_flags_stack_test
	import crf_pkg::*;
;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	crf_dbus_type dbus_in = '0;
	crf_pc_cmd_type pc_cmd_in = '0;
	crf_flag_upd_type flag_upd_in = '0;
	logic [11:0] int_vector_in, nmi_vector_in, program_counter_out;
	logic [7:0] rdata_out, result_register_out, pointer_one_out, pointer_two_out;
	logic rvalid_out;
	crf_flags_type flags_out;
	crf_ctx_type context_out;
	logic [2:0] stack_depth_out;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;
	crf_vec_model u_vec (.int_vector_out(int_vector_in), .nmi_vector_out(nmi_vector_in));
	crf_core_regs u_dut (.clk_in, .rst_n_in, .dbus_in, .pc_cmd_in, .int_vector_in, .nmi_vector_in,
		.flag_upd_in, .rdata_out, .rvalid_out, .program_counter_out, .result_register_out,
		.pointer_one_out, .pointer_two_out, .flags_out, .context_out, .stack_depth_out);
	// ****
	// clock, timeout, drivers
	// ****
	initial forever #25 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			close_out();
		end
	end
	task automatic cmd(crf_pc_op_type op, logic [11:0] tg, logic [7:0] off = 8'h00, logic bk = 1'b0, logic ix = 1'b0);
		@(posedge clk_in);
		pc_cmd_in <= '{op, ix, tg, off, bk};
		@(posedge clk_in);
		pc_cmd_in <= '0;
		#1;
	endtask
	task automatic upd(logic c, logic z);
		@(posedge clk_in);
		flag_upd_in <= '{1'b1, c, 1'b1, z};
		@(posedge clk_in);
		flag_upd_in <= '0;
		#1;
	endtask
	task automatic acc(logic r, logic [7:0] a, logic [7:0] d);
		@(posedge clk_in);
		dbus_in <= '{r, ~r, a, d};
		@(posedge clk_in);
		dbus_in <= '0;
		#1;
	endtask
	task automatic ctx_is(crf_ctx_type c, logic [1:0] f);
		`CHK(context_out, c)
		`CHK(flags_out, f)
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_regs;
		logic [7:0] map [5] = '{ADDR_POINTER_ONE, ADDR_POINTER_TWO, ADDR_SHORT_DIRECT_FIRST,
			ADDR_SHORT_DIRECT_SECOND, ADDR_RESULT_REGISTER};
		`CHK(context_out, CTX_NMI)
		`CHK(program_counter_out, PC_RESET_VECTOR)
		for (int i = 0; i < 5; i++)
			acc(1'b0, map[i], 8'hA0 + 8'(i));
		`CHK(pointer_two_out, 8'hA1)
		`CHK(pointer_one_out, 8'hA0)
		`CHK(result_register_out, 8'hA4)
		for (int i = 0; i < 5; i++) begin
			acc(1'b1, map[i], 8'h00);
			`CHK(rvalid_out, 1'b1)
			`CHK(rdata_out, 8'hA0 + 8'(i))
		end
		acc(1'b1, 8'h84, 8'h00);
		`CHK(rvalid_out, 1'b0)
		$display("t_regs done");
	endtask
	task automatic t_pc;
		cmd(PCS_INCREMENT, 12'h000);
		`CHK(program_counter_out, 12'hFFF)
		cmd(PCS_INCREMENT, 12'h000);
		`CHK(program_counter_out, PC_ZERO)
		cmd(PCS_JUMP_ABSOLUTE, 12'h100);
		cmd(PCS_RELATIVE, 12'h000, 8'h10);
		`CHK(program_counter_out, 12'h110)
		cmd(PCS_RELATIVE, 12'h000, 8'h20, 1'b1);
		`CHK(program_counter_out, 12'h0F0)
		cmd(PCS_CALL, 12'h345);
		`CHK(program_counter_out, 12'h345)
		cmd(PCS_RETURN, 12'h000);
		`CHK(program_counter_out, 12'h0F0)
		$display("t_pc done");
	endtask
	task automatic t_flags;
		upd(1'b1, 1'b1);
		ctx_is(CTX_NMI, 2'b11);
		cmd(PCS_RETURN, 12'h000, 8'h00, 1'b0, 1'b1);
		ctx_is(CTX_NORMAL, 2'b00);
		upd(1'b0, 1'b1);
		cmd(PCS_INTERRUPT, 12'h000);
		`CHK(program_counter_out, 12'h400)
		ctx_is(CTX_INTERRUPT, 2'b00);
		upd(1'b1, 1'b0);
		cmd(PCS_RETURN, 12'h000, 8'h00, 1'b0, 1'b1);
		ctx_is(CTX_NORMAL, 2'b01);
		cmd(PCS_NMI, 12'h000);
		`CHK(program_counter_out, 12'h500)
		ctx_is(CTX_NMI, 2'b11);
		cmd(PCS_RETURN, 12'h000, 8'h00, 1'b0, 1'b1);
		ctx_is(CTX_NORMAL, 2'b01);
		cmd(PCS_INTERRUPT, 12'h000);
		ctx_is(CTX_INTERRUPT, 2'b10);
		cmd(PCS_RETURN, 12'h000, 8'h00, 1'b0, 1'b1);
		ctx_is(CTX_NORMAL, 2'b01);
		$display("t_flags done");
	endtask
	task automatic t_stack;
		cmd(PCS_JUMP_ABSOLUTE, 12'h200);
		for (int i = 1; i < 8; i++)
			cmd(PCS_CALL, 12'h300 + 12'(i));
		`CHK(stack_depth_out, DEPTH_FULL)
		for (int i = 6; i > 0; i--) begin
			cmd(PCS_RETURN, 12'h000);
			`CHK(program_counter_out, 12'h300 + 12'(i))
		end
		cmd(PCS_RETURN, 12'h000);
		`CHK(program_counter_out, 12'h302)
		`CHK(stack_depth_out, DEPTH_ZERO)
		$display("t_stack done");
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		#1;
		t_regs();
		t_pc();
		t_flags();
		t_stack();
		close_out();
	end
endmodule
bind crf_core_regs crf_core_regs_assertions u_chk (.clk_in, .rst_n_in, .dbus_in, .pc_cmd_in,
	.int_vector_in, .flag_upd_in, .rdata_out, .rvalid_out, .program_counter_out, .pointer_one_out,
	.flags_out, .context_out, .stack_depth_out);
`default_nettype wire
